// ### core/sce_engine.v
// Statistics counter engine: event queue, counter update, interrupt queue
`timescale 1ns/1ps
`include "sce_consts.vh"

module sce_engine (
    input  wire                   i_clock,            // System clock
    input  wire                   i_srst,             // Sync reset, high
    // Counter event producers
    input  wire                   i_evt_valid,        // Event offered
    input  wire [`SCE_AW-1:0]     i_evt_addr,         // Counter word address
    input  wire [`SCE_INCW-1:0]   i_evt_incr,         // Increment value
    output wire                   o_evt_ready,        // Event accepted when high
    // Control bits
    input  wire                   i_proc_enable,      // Processing enable
    input  wire                   i_destructive_read, // Clear on host read
    input  wire                   i_first_interrupt_mask, // Masks the pin
    output reg                    o_first_interrupt_status, // Queue not empty
    output reg                    o_first_interrupt_pin,    // Interrupt out
    // Host access
    input  wire                   i_host_req,         // Access request, level
    input  wire                   i_host_we,          // Write when high
    input  wire [`SCE_AW-1:0]     i_host_address_bus, // Word address
    input  wire [`SCE_DW-1:0]     i_host_wdata,       // Write data
    output reg                    o_host_ack,         // Done, one cycle
    output reg  [`SCE_DW-1:0]     o_host_rdata,       // Read data
    // External statistics RAM
    output reg                    o_ram_req,          // Access request
    output reg                    o_ram_we,           // Write when high
    output reg  [`SCE_AW-1:0]     o_ram_addr,         // Word address
    output reg  [`SCE_DW-1:0]     o_ram_wdata,        // Write data
    input  wire                   i_ram_ack,          // Access done, pulse
    input  wire [`SCE_DW-1:0]     i_ram_rdata         // Read data at ack
);

    // Engine states
    localparam [2:0] S_IDLE = 3'h0;  // Waiting for work
    localparam [2:0] S_CRD  = 3'h1;  // Counter read
    localparam [2:0] S_TRD  = 3'h2;  // Threshold read
    localparam [2:0] S_IQW  = 3'h3;  // Interrupt entry write
    localparam [2:0] S_CWR  = 3'h4;  // Counter write back
    localparam [2:0] S_HACC = 3'h5;  // Plain host access
    localparam [2:0] S_HCLR = 3'h6;  // Destructive clear
    localparam [2:0] S_HIQ  = 3'h7;  // Window read of queue head

    reg [2:0]              state;     // Current state
    reg [`SCE_AW-1:0]      ev_addr;   // Event counter address
    reg [`SCE_INCW-1:0]    ev_incr;   // Event increment
    reg [`SCE_VAL_MSB:0]   cnt_val;   // Updated counter value
    reg [`SCE_AW-1:0]      h_addr;    // Latched host address
    // Queue indices survive a disable so pending entries stay readable
    reg [`SCE_IQ_AW-1:0]   iq_wr;     // Queue write index
    reg [`SCE_IQ_AW-1:0]   iq_rd;     // Queue read index
    reg [`SCE_IQ_AW:0]     iq_cnt;    // Entries pending

    wire [`SCE_AW+`SCE_INCW-1:0] fifo_data;  // Head event
    wire                         fifo_valid; // Event pending

    // True when an address falls in the interrupt queue window
    function in_iq;
        input [`SCE_AW-1:0] a;
        begin
            in_iq = (a[`SCE_REG_MSB:`SCE_REG_LSB] == `SCE_IQ_REGION);
        end
    endfunction

    // Host wins the idle slot so register traffic is never starved
    // A request still high beside its own ack is the old one, not a new one
    wire host_go  = (state == S_IDLE) & i_host_req & ~o_host_ack;
    // Events wait while the host holds the slot or processing is off
    wire evt_pop  = (state == S_IDLE) & ~host_go & fifo_valid
                  & i_proc_enable;

    // Saturating add on the fetched counter
    // Sum is one bit wider so a carry past the maximum is still seen
    wire [`SCE_VAL_MSB:0] ram_val = i_ram_rdata[`SCE_VAL_MSB:0];
    wire [`SCE_VAL_MSB+1:0] sum = {1'b0, ram_val}
                                + {{(`SCE_VAL_MSB+1-`SCE_INCW){1'b0}}, ev_incr};
    wire at_max   = (ram_val >= `SCE_CNT_MAX);
    wire over_max = (sum > {1'b0, `SCE_CNT_MAX});
    wire [`SCE_VAL_MSB:0] sat_val = at_max   ? ram_val :
                                    over_max ? `SCE_CNT_MAX :
                                               sum[`SCE_VAL_MSB:0];

    // Threshold hit: active flag set and value reached
    // Compared with the updated value, so the event that crosses
    // the threshold is the one that reports it
    wire thr_hit = i_ram_rdata[`SCE_FLAG_BIT]
                 & (cnt_val >= ram_val);
    // A full queue never overwrites entries the host has not read
    wire iq_full = (iq_cnt == `SCE_IQ_DEPTH);

    // Entry built from the counter address fields
    // Top bit marks a written slot, zeros pad down to the port field
    wire [`SCE_DW-1:0] entry = {1'b1,
        {(`SCE_DW-1-`SCE_PORT_MSB){1'b0}},
        ev_addr[`SCE_PORT_MSB:`SCE_PORT_LSB],
        ev_addr[`SCE_CHAN_MSB:`SCE_CHAN_LSB],
        ev_addr[`SCE_CTR_MSB:`SCE_CTR_LSB]};

    // Producers see ready straight from the queue's own register
    sce_event_fifo u_fifo (
        .i_clock (i_clock),
        .i_srst  (i_srst),
        .i_push  (i_evt_valid),
        .i_data  ({i_evt_addr, i_evt_incr}),
        .i_pop   (evt_pop),
        .o_data  (fifo_data),
        .o_valid (fifo_valid),
        .o_ready (o_evt_ready)
    );

    // Status and pin follow the pending count one cycle later
    // Mask gates only the pin; status stays visible for polling
    always @(posedge i_clock) begin
        if (i_srst) begin
            o_first_interrupt_status <= 1'b0;
            o_first_interrupt_pin    <= 1'b0;
        end else begin
            o_first_interrupt_status <= (iq_cnt != {(`SCE_IQ_AW+1){1'b0}});
            o_first_interrupt_pin    <= (iq_cnt != {(`SCE_IQ_AW+1){1'b0}})
                                      & ~i_first_interrupt_mask;
        end
    end

    // Main sequencer: one RAM access at a time
    // Every RAM access holds its address until the ack is seen
    always @(posedge i_clock) begin
        if (i_srst) begin
            state        <= S_IDLE;
            ev_addr      <= {`SCE_AW{1'b0}};
            ev_incr      <= {`SCE_INCW{1'b0}};
            cnt_val      <= {(`SCE_VAL_MSB+1){1'b0}};
            h_addr       <= {`SCE_AW{1'b0}};
            iq_wr        <= {`SCE_IQ_AW{1'b0}};
            iq_rd        <= {`SCE_IQ_AW{1'b0}};
            iq_cnt       <= {(`SCE_IQ_AW+1){1'b0}};
            o_host_ack   <= 1'b0;
            o_host_rdata <= {`SCE_DW{1'b0}};
            o_ram_req    <= 1'b0;
            o_ram_we     <= 1'b0;
            o_ram_addr   <= {`SCE_AW{1'b0}};
            o_ram_wdata  <= {`SCE_DW{1'b0}};
        end else begin
            o_host_ack <= 1'b0;
            case (state)
            S_IDLE: begin
                // Host first, then the next queued event
                if (host_go) begin
                    // Kept for the clear that may follow a read
                    h_addr <= i_host_address_bus;
                    if (i_proc_enable && in_iq(i_host_address_bus)) begin
                        // Window: address bits below the region ignored
                        if (i_host_we) begin
                            // Writes through the window are acked and dropped
                            o_host_ack <= 1'b1;
                        end else if (iq_cnt == {(`SCE_IQ_AW+1){1'b0}}) begin
                            // Empty queue reads as all zero
                            o_host_rdata <= {`SCE_DW{1'b0}};
                            o_host_ack   <= 1'b1;
                        end else begin
                            // Head entry fetched at the read index
                            o_ram_req  <= 1'b1;
                            o_ram_we   <= 1'b0;
                            o_ram_addr <= `SCE_IQ_BASE
                                        | {{(`SCE_AW-`SCE_IQ_AW){1'b0}}, iq_rd};
                            state      <= S_HIQ;
                        end
                    end else begin
                        // Plain access, whole RAM when disabled
                        o_ram_req   <= 1'b1;
                        o_ram_we    <= i_host_we;
                        o_ram_addr  <= i_host_address_bus;
                        o_ram_wdata <= i_host_wdata;
                        state       <= S_HACC;
                    end
                end else if (evt_pop) begin
                    // Counter word is read first
                    ev_addr    <= fifo_data[`SCE_AW+`SCE_INCW-1:`SCE_INCW];
                    ev_incr    <= fifo_data[`SCE_INCW-1:0];
                    o_ram_req  <= 1'b1;
                    o_ram_we   <= 1'b0;
                    o_ram_addr <= fifo_data[`SCE_AW+`SCE_INCW-1:`SCE_INCW];
                    state      <= S_CRD;
                end
            end
            S_CRD: begin
                // Keep the saturated sum, then read the threshold
                if (i_ram_ack) begin
                    cnt_val    <= sat_val;
                    o_ram_addr <= ev_addr + `SCE_THR_OFS;
                    state      <= S_TRD;
                end
            end
            S_TRD: begin
                // Threshold word in, decide on an entry
                if (i_ram_ack) begin
                    // A full queue loses the entry; flag shows it was not written
                    if (thr_hit && !iq_full) begin
                        o_ram_we    <= 1'b1;
                        o_ram_addr  <= `SCE_IQ_BASE
                                     | {{(`SCE_AW-`SCE_IQ_AW){1'b0}}, iq_wr};
                        o_ram_wdata <= entry;
                        state       <= S_IQW;
                    end else begin
                        // No entry: counter goes back with its flag clear
                        o_ram_we    <= 1'b1;
                        o_ram_addr  <= ev_addr;
                        o_ram_wdata <= {1'b0, cnt_val};
                        state       <= S_CWR;
                    end
                end
            end
            S_IQW: begin
                if (i_ram_ack) begin
                    iq_wr       <= iq_wr + 1'b1;
                    iq_cnt      <= iq_cnt + 1'b1;
                    // Entry landed, counter goes back with its flag set
                    o_ram_addr  <= ev_addr;
                    o_ram_wdata <= {1'b1, cnt_val};
                    state       <= S_CWR;
                end
            end
            S_CWR: begin
                // Write back done, RAM released
                if (i_ram_ack) begin
                    o_ram_req <= 1'b0;
                    o_ram_we  <= 1'b0;
                    state     <= S_IDLE;
                end
            end
            S_HACC: begin
                // Write data is not echoed, reads return the word
                if (i_ram_ack) begin
                    o_host_rdata <= o_ram_we ? {`SCE_DW{1'b0}} : i_ram_rdata;
                    o_host_ack   <= 1'b1;
                    // Clear any word outside the queue window, thresholds too, never the window itself
                    if (!o_ram_we && i_destructive_read && !in_iq(h_addr)) begin
                        o_ram_we    <= 1'b1;
                        o_ram_wdata <= {`SCE_DW{1'b0}};
                        state       <= S_HCLR;
                    end else begin
                        // Plain access finished
                        o_ram_req <= 1'b0;
                        o_ram_we  <= 1'b0;
                        state     <= S_IDLE;
                    end
                end
            end
            S_HCLR: begin
                // Zero lands after the value went out
                if (i_ram_ack) begin
                    o_ram_req <= 1'b0;
                    o_ram_we  <= 1'b0;
                    state     <= S_IDLE;
                end
            end
            S_HIQ: begin
                // Head entry in, read index advances
                if (i_ram_ack) begin
                    // Top bit tells the host whether more entries follow
                    o_host_rdata <= {(iq_cnt > {{`SCE_IQ_AW{1'b0}}, 1'b1}),
                                     i_ram_rdata[`SCE_DW-2:0]};
                    o_host_ack   <= 1'b1;
                    iq_rd        <= iq_rd + 1'b1;
                    iq_cnt       <= iq_cnt - 1'b1;
                    o_ram_req    <= 1'b0;
                    state        <= S_IDLE;
                end
            end
            default: begin
                // Unused code, back to idle
                o_ram_req <= 1'b0;
                o_ram_we  <= 1'b0;
                state     <= S_IDLE;
            end
            endcase
        end
    end

endmodule

// ### core/sce_consts.vh
// Constants for the statistics counter engine
`ifndef SCE_CONSTS_VH
`define SCE_CONSTS_VH

// Bus and field widths, queue depths
`define SCE_AW          18
`define SCE_DW          32
`define SCE_INCW        16
`define SCE_FIFO_AW     8
`define SCE_FIFO_DEPTH  9'h100
`define SCE_IQ_AW       8
`define SCE_IQ_DEPTH    9'h100

// Counter saturation value
`define SCE_CNT_MAX     31'h40000000

// Counter word: flag bit over a 31-bit value
`define SCE_FLAG_BIT    31
`define SCE_VAL_MSB     30

// Interrupt queue window: upper address bits select it
`define SCE_REG_MSB     17
`define SCE_REG_LSB     13
`define SCE_IQ_REGION   5'h1F
`define SCE_IQ_BASE     18'h3F000

// Entry fields taken from the counter address
`define SCE_PORT_MSB    17
`define SCE_PORT_LSB    15
`define SCE_CHAN_MSB    14
`define SCE_CHAN_LSB    7
`define SCE_CTR_MSB     6
`define SCE_CTR_LSB     1

// Offset of the threshold word from the counter word
`define SCE_THR_OFS     18'h00001

`endif

// ### core/sce_event_fifo.v
// Event queue holding counter events until the engine takes them
`timescale 1ns/1ps
`include "sce_consts.vh"

module sce_event_fifo (
    input  wire                                i_clock,  // System clock
    input  wire                                i_srst,   // Sync reset, high
    input  wire                                i_push,   // Write one event
    input  wire [`SCE_AW+`SCE_INCW-1:0]        i_data,   // Address and increment
    input  wire                                i_pop,    // Take the head event
    output wire [`SCE_AW+`SCE_INCW-1:0]        o_data,   // Head event
    output wire                                o_valid,  // Queue holds an event
    output reg                                 o_ready   // Room for one more
);

    reg [`SCE_AW+`SCE_INCW-1:0] mem [0:(1<<`SCE_FIFO_AW)-1]; // Event storage
    reg [`SCE_FIFO_AW-1:0]      wr_ptr;                     // Next free slot
    reg [`SCE_FIFO_AW-1:0]      rd_ptr;                     // Head slot
    reg [`SCE_FIFO_AW:0]        count;                      // Events held

    wire do_push = i_push & o_ready;   // Full queue refuses, never drops
    wire do_pop  = i_pop & o_valid;    // Empty queue ignores a pop
    wire [`SCE_FIFO_AW:0] next_count = count + {{`SCE_FIFO_AW{1'b0}}, do_push}
                                     - {{`SCE_FIFO_AW{1'b0}}, do_pop};

    assign o_data  = mem[rd_ptr];
    assign o_valid = (count != {(`SCE_FIFO_AW+1){1'b0}});

    // Storage array, no reset needed
    always @(posedge i_clock) begin
        if (do_push) begin
            mem[wr_ptr] <= i_data;
        end
    end

    // Pointers, fill level and registered ready
    always @(posedge i_clock) begin
        if (i_srst) begin
            wr_ptr  <= {`SCE_FIFO_AW{1'b0}};
            rd_ptr  <= {`SCE_FIFO_AW{1'b0}};
            count   <= {(`SCE_FIFO_AW+1){1'b0}};
            o_ready <= 1'b0;
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count   <= next_count;
            // Ready returns the cycle after a slot frees
            o_ready <= (next_count != `SCE_FIFO_DEPTH);
        end
    end

endmodule

// ### verif/sce_assertions.sv
// Concurrent checks on the statistics counter engine ports
`timescale 1ns/1ps
`include "sce_consts.vh"

module sce_assertions (
    input wire                 i_clock,                  // System clock
    input wire                 i_srst,                   // Sync reset
    input wire                 i_proc_enable,            // Processing enable
    input wire                 i_destructive_read,       // Clear on read
    input wire                 i_first_interrupt_mask,   // Pin mask
    input wire                 o_first_interrupt_status, // Queue not empty
    input wire                 o_first_interrupt_pin,    // Interrupt out
    input wire                 i_host_req,               // Host request
    input wire                 o_host_ack,               // Host done
    input wire [`SCE_DW-1:0]   o_host_rdata,             // Host read data
    input wire                 o_ram_req,                // RAM request
    input wire                 o_ram_we,                 // RAM write
    input wire [`SCE_AW-1:0]   o_ram_addr,               // RAM address
    input wire [`SCE_DW-1:0]   o_ram_wdata,              // RAM write data
    input wire                 i_ram_ack,                // RAM done
    input wire                 o_evt_ready               // Event room
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_srst);

    // Queue stays closed on the release edge, opens one edge later
    reset_out_a: assert property ($fell(i_srst) |-> !o_evt_ready ##1 o_evt_ready)
        else $error("event ready wrong after reset");
    // Acknowledge is a single pulse
    ack_pulse_a: assert property (o_host_ack |=> !o_host_ack)
        else $error("host ack longer than one cycle");
    // No acknowledge without a request behind it
    ack_cause_a: assert property (o_host_ack |-> $past(i_host_req))
        else $error("host ack without request");
    // Read data only moves with an acknowledge
    rdata_hold_a: assert property (!o_host_ack |-> $stable(o_host_rdata))
        else $error("host read data moved without ack");
    // RAM request and its qualifiers held until answered
    ram_hold_a: assert property (o_ram_req && !i_ram_ack |=>
        o_ram_req && $stable(o_ram_addr) && $stable(o_ram_we) && $stable(o_ram_wdata))
        else $error("RAM request changed before ack");
    // Counter words never pass the saturation value
    sat_limit_a: assert property (o_ram_req && o_ram_we &&
        o_ram_addr[`SCE_REG_MSB:`SCE_REG_LSB] != `SCE_IQ_REGION
        |-> o_ram_wdata[`SCE_VAL_MSB:0] <= `SCE_CNT_MAX)
        else $error("counter written above maximum");
    // Unmasked pending status drives the pin
    pin_on_a: assert property (o_first_interrupt_status && !i_first_interrupt_mask &&
        $past(o_first_interrupt_status && !i_first_interrupt_mask) |-> o_first_interrupt_pin)
        else $error("interrupt pin low while unmasked and pending");
    // Mask keeps the pin low
    mask_block_a: assert property (i_first_interrupt_mask [*2] |-> !o_first_interrupt_pin)
        else $error("interrupt pin high while masked");
    // Disabled and unaddressed engine leaves RAM alone
    dis_idle_a: assert property ((!i_proc_enable && !i_host_req && !i_destructive_read) [*4]
        |-> !o_ram_req)
        else $error("RAM used while processing disabled");

    // Main scenarios reached
    cover property (o_host_ack && o_host_rdata[`SCE_DW-1]);
    cover property ($rose(o_first_interrupt_pin));
    cover property ($fell(o_evt_ready));
endmodule

// ### verif/sce_ram_model.sv
// External statistics RAM with selectable answer latency
`timescale 1ns/1ps
`include "sce_consts.vh"

module sce_ram_model (
    input  wire                 i_clock, // System clock
    input  wire                 i_slow,  // Three wait cycles when high
    input  wire                 i_req,   // Access request
    input  wire                 i_we,    // Write when high
    input  wire [`SCE_AW-1:0]   i_addr,  // Word address
    input  wire [`SCE_DW-1:0]   i_wdata, // Write data
    output reg                  o_ack,   // Done pulse
    output reg  [`SCE_DW-1:0]   o_rdata  // Read data at ack
);
    reg [`SCE_DW-1:0] mem [0:(1<<`SCE_AW)-1]; // Storage, bench preloads
    reg [1:0]         cnt;                    // Wait counter

    initial begin
        o_ack   = 1'b0;
        o_rdata = 32'h0;
        cnt     = 2'h0;
    end

    // Skip the ack edge so one request is never answered twice
    always @(posedge i_clock) begin
        o_ack   <= 1'b0;
        o_rdata <= ~o_rdata; // Stale data never looks valid
        if (i_req && !o_ack) begin
            if (cnt == (i_slow ? 2'h3 : 2'h0)) begin
                o_ack <= 1'b1;
                cnt   <= 2'h0;
                if (i_we)
                    mem[i_addr] <= i_wdata;
                else
                    o_rdata <= mem[i_addr];
            end else begin
                cnt <= cnt + 2'h1;
            end
        end
    end
endmodule

// ### verif/sce_engine_tb.sv
// Self-checking bench for the statistics counter engine
`timescale 1ns/1ps
`include "sce_consts.vh"

module sce_engine_tb;
    reg clk, rst, ev, en, dr, msk, hr, hw, slow; // Drive bits
    reg  [17:0] ea, ha;                          // Event and host address
    reg  [15:0] ei;                              // Event increment
    reg  [31:0] hd, q;                           // Host write and read data
    wire        rdy, sts, pin, hack, rreq, rwe, rack; // Design outputs and RAM ack
    wire [31:0] hq, rwd, rrd;                    // Data buses
    wire [17:0] rad;                             // RAM address
    integer     failures, tests_run, i;          // Counts

    localparam [17:0] A = 18'h10A94, B = 18'h02000, C = 18'h08100;
    localparam [17:0] D = 18'h0C204, E = 18'h04008;

    sce_engine u_sce_engine (.i_clock(clk), .i_srst(rst), .i_evt_valid(ev),
        .i_evt_addr(ea), .i_evt_incr(ei), .o_evt_ready(rdy), .i_proc_enable(en),
        .i_destructive_read(dr), .i_first_interrupt_mask(msk),
        .o_first_interrupt_status(sts), .o_first_interrupt_pin(pin), .i_host_req(hr),
        .i_host_we(hw), .i_host_address_bus(ha), .i_host_wdata(hd), .o_host_ack(hack),
        .o_host_rdata(hq), .o_ram_req(rreq), .o_ram_we(rwe), .o_ram_addr(rad),
        .o_ram_wdata(rwd), .i_ram_ack(rack), .i_ram_rdata(rrd));
    sce_ram_model u_sce_ram_model (.i_clock(clk), .i_slow(slow), .i_req(rreq), .i_we(rwe),
        .i_addr(rad), .i_wdata(rwd), .o_ack(rack), .o_rdata(rrd));

    // Clock, 4 ns period
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Mismatch report
    task chk(input [8*10-1:0] n, input [31:0] e, input [31:0] g);
        begin
            tests_run = tests_run + 1;
            if (g !== e) begin
                failures = failures + 1;
                $display("[FAIL] %0s expected %h seen %h", n, e, g);
            end
        end
    endtask

    // Offer one event, held until taken
    task push(input [17:0] a, input [15:0] n);
        begin
            ea <= a;
            ei <= n;
            ev <= 1'b1;
            do @(posedge clk); while (rdy !== 1'b1);
        end
    endtask

    // Host access, request dropped on the ack edge
    task host(input w, input [17:0] a, input [31:0] d);
        begin
            hw <= w; ha <= a; hd <= d; hr <= 1'b1; i = 0;
            do begin @(posedge clk); i = i + 1; end while (hack !== 1'b1 && i < 500);
            if (i >= 500) failures = failures + 1;
            q = hq;
            hr <= 1'b0;
            @(posedge clk);
        end
    endtask

    // Bounded wait for a RAM word, then compare
    task wmem(input [17:0] a, input [31:0] e);
        begin
            i = 0;
            while (u_sce_ram_model.mem[a] !== e && i < 3000) begin @(posedge clk); i = i + 1; end
            chk("ram word", e, u_sce_ram_model.mem[a]);
        end
    endtask

    // Expected window word: more flag over port, channel, counter
    function [31:0] ent(input [17:0] a, input m);
        ent = {m, 14'h0, a[17:1]};
    endfunction

    task end_of_test;
        begin
            $display("comparisons %0d mismatches %0d", tests_run, failures);
            if (failures == 0 && tests_run > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask

    // Plain counting, polling threshold, saturation and ordering
    task t_count;
        begin
            u_sce_ram_model.mem[A] = 32'h0; u_sce_ram_model.mem[A+1] = 32'h10;
            u_sce_ram_model.mem[B] = 32'h3FFFFFFE; u_sce_ram_model.mem[B+1] = 32'h0;
            push(A, 16'h5); ev <= 1'b0;
            wmem(A, 32'h5);
            push(A, 16'hC); push(B, 16'h5); push(B, 16'h1); push(A, 16'h1); ev <= 1'b0;
            wmem(A, 32'h12);
            chk("saturate", 32'h40000000, u_sce_ram_model.mem[B]);
            chk("status", 32'h0, {31'h0, sts});
        end
    endtask

    // Active thresholds, pin, mask, window reads
    task t_irq;
        begin
            slow <= 1'b1;
            u_sce_ram_model.mem[C] = 32'h8; u_sce_ram_model.mem[C+1] = 32'h8000000A;
            u_sce_ram_model.mem[D] = 32'h0; u_sce_ram_model.mem[D+1] = 32'h80000001;
            push(C, 16'h3); push(D, 16'h2); ev <= 1'b0;
            wmem(D, 32'h80000002);
            chk("int_gen", 32'h8000000B, u_sce_ram_model.mem[C]);
            repeat (3) @(posedge clk);
            chk("status", 32'h1, {31'h0, sts});
            chk("pin", 32'h1, {31'h0, pin});
            msk <= 1'b1; repeat (3) @(posedge clk);
            chk("pin mask", 32'h0, {31'h0, pin});
            msk <= 1'b0;
            host(1'b1, 18'h3F000, 32'hFFFFFFFF);
            host(1'b0, 18'h3F5A6, 32'h0);
            chk("window 1", ent(C, 1'b1), q);
            host(1'b0, 18'h3E002, 32'h0);
            chk("window 2", ent(D, 1'b0), q);
            repeat (3) @(posedge clk);
            chk("status", 32'h0, {31'h0, sts});
            chk("pin", 32'h0, {31'h0, pin});
            slow <= 1'b0;
        end
    endtask

    // Clear on read
    task t_dest;
        begin
            dr <= 1'b1;
            host(1'b0, A, 32'h0);
            chk("read", 32'h12, q);
            wmem(A, 32'h0);
            dr <= 1'b0;
        end
    endtask

    // Disabled: queue fills and stalls, raw queue access, then drain
    task t_full;
        begin
            u_sce_ram_model.mem[E] = 32'h0; u_sce_ram_model.mem[E+1] = 32'h0;
            en <= 1'b0; @(posedge clk);
            repeat (256) push(E, 16'h1);
            ev <= 1'b0; repeat (2) @(posedge clk);
            chk("ready", 32'h0, {31'h0, rdy});
            chk("idle", 32'h0, u_sce_ram_model.mem[E]);
            host(1'b1, 18'h3F010, 32'hA5A51234);
            host(1'b0, 18'h3F010, 32'h0);
            chk("raw queue", 32'hA5A51234, q);
            en <= 1'b1;
            wmem(E, 32'h100);
            chk("ready", 32'h1, {31'h0, rdy});
        end
    endtask

    // Hang guard
    initial begin
        #200000;
        failures = failures + 1;
        end_of_test;
    end

    initial begin
        failures = 0; tests_run = 0; rst = 1'b1; ev = 1'b0; en = 1'b0; dr = 1'b0;
        msk = 1'b0; hr = 1'b0; hw = 1'b0; slow = 1'b0; ea = 18'h0; ha = 18'h0;
        ei = 16'h0; hd = 32'h0;
        repeat (10) @(posedge clk);
        rst <= 1'b0; en <= 1'b1;
        repeat (2) @(posedge clk);
        t_count;
        t_irq;
        t_dest;
        t_full;
        end_of_test;
    end
endmodule

bind sce_engine sce_assertions u_sce_assertions (.i_clock(i_clock), .i_srst(i_srst),
    .i_proc_enable(i_proc_enable), .i_destructive_read(i_destructive_read),
    .i_first_interrupt_mask(i_first_interrupt_mask),
    .o_first_interrupt_status(o_first_interrupt_status),
    .o_first_interrupt_pin(o_first_interrupt_pin), .i_host_req(i_host_req),
    .o_host_ack(o_host_ack), .o_host_rdata(o_host_rdata), .o_ram_req(o_ram_req),
    .o_ram_we(o_ram_we), .o_ram_addr(o_ram_addr), .o_ram_wdata(o_ram_wdata),
    .i_ram_ack(i_ram_ack), .o_evt_ready(o_evt_ready));
